//--- rtl/ddc_regs.svh
// register offsets, field positions, reset values for the dual converter control block
// Summary of operation
// - Control bit 7 set selects 8-bit mode for both channels using only the low code register, clear selects 12-bit mode.
// - Control bits 6 and 5 pick the range of channel 1 and channel 0, 1 for zero to analogue supply, 0 for zero to reference.
// - Control bits 4 and 3 at 0 force channel 1 and channel 0 to zero volts, at 1 the output follows its code.
// - With control bit 2 set, a channel's output updates as soon as its low code register is written.
// - With control bit 2 clear, code writes are held back and both channels update together when the bit is set.
// - Control bits 1 and 0 power channel 1 and channel 0 on when 1 and off when 0.
// - A 12-bit code is right-justified, low register holding bits 7:0 and the high register low nibble bits 11:8.
// - All four code registers reset to zero.
// - The control register resets to 04H.
// - A powered-off channel holds its output in high impedance until enabled.
`ifndef DDC_REGS_SVH
`define DDC_REGS_SVH
`define DDC_OFS_C0_LOW 8'hF9
`define DDC_OFS_C0_HIGH 8'hFA
`define DDC_OFS_C1_LOW 8'hFB
`define DDC_OFS_C1_HIGH 8'hFC
`define DDC_OFS_CTRL 8'hFD
`define DDC_BIT_MODE 7
`define DDC_BIT_C1_RANGE 6
`define DDC_BIT_C0_RANGE 5
`define DDC_BIT_C1_ZERO_N 4
`define DDC_BIT_C0_ZERO_N 3
`define DDC_BIT_SYNC 2
`define DDC_BIT_PWR1 1
`define DDC_BIT_PWR0 0
`define DDC_RST_CTRL 8'h04
`define DDC_RST_CODE 8'h00
`endif

//--- rtl/ddc_pkg.sv
// types shared by the dual converter control block
package ddc_pkg;
   typedef logic [11:0] ddc_code_t;
   typedef struct packed {
      ddc_code_t code;
      logic range_supply;
      logic enable;
   } ddc_chan_t;
endpackage

//--- rtl/ddc_chan_out.sv
// one converter channel: applied code latch and output drive
`timescale 1ns/1ps
`include "ddc_regs.svh"
module ddc_chan_out
   import ddc_pkg::*;
(
   input wire logic clk, // core clock
   input wire logic rst_n, // async reset, active low
   input wire logic load, // apply pending code this cycle
   input wire ddc_code_t pending, // code formed from the registers
   input wire logic force_zero_n, // 0 drives zero code
   input wire logic range_supply, // range select
   input wire logic power_on, // channel power
   output ddc_chan_t chan // drive to the analogue channel
);
   ddc_code_t applied_q;
   ddc_code_t applied_d;
   assign applied_d = load ? pending : applied_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         applied_q <= 12'h000;
      end else begin
         applied_q <= applied_d;
      end
   end
   // clear overrides the code but leaves it latched for later
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chan <= '0;
      end else begin
         chan.code <= force_zero_n ? applied_d : 12'h000;
         chan.range_supply <= range_supply;
         chan.enable <= power_on;
      end
   end
endmodule

//--- rtl/ddc_top.sv
// dual converter register control: special-function registers and channel update
`timescale 1ns/1ps
`include "ddc_regs.svh"
module ddc_top
   import ddc_pkg::*;
(
   input wire logic SYS_CLK, // 125 MHz core clock
   input wire logic RESET_N, // async reset, active low
   input wire logic [7:0] SFR_ADDR, // register address
   input wire logic SFR_WR, // write strobe, one cycle
   input wire logic [7:0] SFR_WDATA, // write data
   input wire logic SFR_RD, // read strobe
   output logic [7:0] SFR_RDATA, // read data, registered
   output logic SFR_SEL, // address hits this block
   output ddc_chan_t CHAN0, // channel 0 drive
   output ddc_chan_t CHAN1, // channel 1 drive
   output logic CHAN0_OE, // channel 0 output enable, low is high impedance
   output logic CHAN1_OE // channel 1 output enable
);
   logic [7:0] ctrl_q;
   logic [7:0] c0_low_q;
   logic [7:0] c0_high_q;
   logic [7:0] c1_low_q;
   logic [7:0] c1_high_q;

   function automatic ddc_code_t form_code(input logic eight_bit, input logic [7:0] lo,
                                           input logic [7:0] hi);
      // upper nibble of the high byte never reaches the code
      form_code = eight_bit ? {lo, 4'h0} : {hi[3:0], lo};
   endfunction

   wire hit_ctrl = SFR_WR && (SFR_ADDR == `DDC_OFS_CTRL);
   wire hit_c0l = SFR_WR && (SFR_ADDR == `DDC_OFS_C0_LOW);
   wire hit_c0h = SFR_WR && (SFR_ADDR == `DDC_OFS_C0_HIGH);
   wire hit_c1l = SFR_WR && (SFR_ADDR == `DDC_OFS_C1_LOW);
   wire hit_c1h = SFR_WR && (SFR_ADDR == `DDC_OFS_C1_HIGH);
   wire sync_now = ctrl_q[`DDC_BIT_SYNC];
   wire sync_rise = hit_ctrl && !sync_now && SFR_WDATA[`DDC_BIT_SYNC];
   wire eight_bit = hit_ctrl ? SFR_WDATA[`DDC_BIT_MODE] : ctrl_q[`DDC_BIT_MODE];

   // write data applies the same cycle the low byte lands
   wire [7:0] c0_low_n = hit_c0l ? SFR_WDATA : c0_low_q;
   wire [7:0] c1_low_n = hit_c1l ? SFR_WDATA : c1_low_q;
   wire [7:0] c0_high_n = hit_c0h ? SFR_WDATA : c0_high_q;
   wire [7:0] c1_high_n = hit_c1h ? SFR_WDATA : c1_high_q;
   wire ddc_code_t code0 = form_code(eight_bit, c0_low_n, c0_high_n);
   wire ddc_code_t code1 = form_code(eight_bit, c1_low_n, c1_high_n);
   wire load0 = (sync_now && hit_c0l) || sync_rise;
   wire load1 = (sync_now && hit_c1l) || sync_rise;
   wire [7:0] ctrl_n = hit_ctrl ? SFR_WDATA : ctrl_q;

   assign SFR_SEL = (SFR_ADDR >= `DDC_OFS_C0_LOW) && (SFR_ADDR <= `DDC_OFS_CTRL);

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ctrl_q <= `DDC_RST_CTRL;
         c0_low_q <= `DDC_RST_CODE;
         c0_high_q <= `DDC_RST_CODE;
         c1_low_q <= `DDC_RST_CODE;
         c1_high_q <= `DDC_RST_CODE;
      end else begin
         ctrl_q <= ctrl_n;
         c0_low_q <= c0_low_n;
         c0_high_q <= c0_high_n;
         c1_low_q <= c1_low_n;
         c1_high_q <= c1_high_n;
      end
   end

   wire [7:0] rd_mux = (SFR_ADDR == `DDC_OFS_C0_LOW) ? c0_low_q :
                       (SFR_ADDR == `DDC_OFS_C0_HIGH) ? c0_high_q :
                       (SFR_ADDR == `DDC_OFS_C1_LOW) ? c1_low_q :
                       (SFR_ADDR == `DDC_OFS_C1_HIGH) ? c1_high_q :
                       (SFR_ADDR == `DDC_OFS_CTRL) ? ctrl_q : 8'h00;

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         SFR_RDATA <= 8'h00;
      end else if (SFR_RD) begin
         SFR_RDATA <= rd_mux;
      end
   end

   ddc_chan_out u_chan0 (
      .clk(SYS_CLK),
      .rst_n(RESET_N),
      .load(load0),
      .pending(code0),
      .force_zero_n(ctrl_n[`DDC_BIT_C0_ZERO_N]),
      .range_supply(ctrl_n[`DDC_BIT_C0_RANGE]),
      .power_on(ctrl_n[`DDC_BIT_PWR0]),
      .chan(CHAN0)
   );
   ddc_chan_out u_chan1 (
      .clk(SYS_CLK),
      .rst_n(RESET_N),
      .load(load1),
      .pending(code1),
      .force_zero_n(ctrl_n[`DDC_BIT_C1_ZERO_N]),
      .range_supply(ctrl_n[`DDC_BIT_C1_RANGE]),
      .power_on(ctrl_n[`DDC_BIT_PWR1]),
      .chan(CHAN1)
   );

   // disabled channel floats; analogue side decodes the enable
   assign CHAN0_OE = CHAN0.enable;
   assign CHAN1_OE = CHAN1.enable;
endmodule

//--- verification/ddc_top_sva.sv
// port assertions for the converter control block
`timescale 1ns/1ps
module ddc_top_sva
   import ddc_pkg::*;
(
   input wire logic SYS_CLK, // clock
   input wire logic RESET_N, // reset
   input wire logic [7:0] SFR_ADDR, // address
   input wire logic SFR_WR, // write
   input wire logic [7:0] SFR_WDATA, // wdata
   input wire logic SFR_RD, // read
   input wire logic [7:0] SFR_RDATA, // rdata
   input wire logic SFR_SEL, // hit
   input wire ddc_chan_t CHAN0, // chan 0
   input wire ddc_chan_t CHAN1, // chan 1
   input wire logic CHAN0_OE, // oe 0
   input wire logic CHAN1_OE // oe 1
);
   logic [7:0] ctl_q;
   wire ctl_wr = SFR_WR && SFR_ADDR == 8'hFD;
   wire c0_wr = SFR_WR && SFR_ADDR == 8'hF9 && ctl_q[2] && ctl_q[3];
   // shadow of the control register, so outputs are tied to what software wrote
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) ctl_q <= 8'h04;
      else if (ctl_wr) ctl_q <= SFR_WDATA;
   end
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);
   sequence s_ctl;
      ctl_wr;
   endsequence
   power_follow_a: assert property (s_ctl |=> CHAN0.enable == $past(SFR_WDATA[0])
      && CHAN1.enable == $past(SFR_WDATA[1])) else $error("power bit mismatch");
   range_sel_a: assert property (s_ctl |=> CHAN1.range_supply == $past(SFR_WDATA[6])
      && CHAN0.range_supply == $past(SFR_WDATA[5])) else $error("range mismatch");
   clear_zero_a: assert property (s_ctl ##0 !SFR_WDATA[3] |=> CHAN0.code == 12'h000)
      else $error("clear not forcing zero");
   imm_load_a: assert property (c0_wr && !ctl_q[7] |=> CHAN0.code[7:0] == $past(SFR_WDATA))
      else $error("immediate load mismatch");
   byte_mode_a: assert property (c0_wr && ctl_q[7] |=> CHAN0.code == {$past(SFR_WDATA), 4'h0})
      else $error("byte mode code mismatch");
   sync_hold_a: assert property (SFR_WR && !ctl_q[2] && !ctl_wr |=> $stable(CHAN0)
      && $stable(CHAN1)) else $error("output moved while held");
   oe_track_a: assert property (CHAN0_OE == ctl_q[0] && CHAN1_OE == ctl_q[1])
      else $error("output enable mismatch");
   ctl_read_a: assert property (SFR_RD && !SFR_WR && SFR_ADDR == 8'hFD |=>
      SFR_RDATA == $past(ctl_q)) else $error("control readback mismatch");
endmodule
bind ddc_top ddc_top_sva u_ddc_top_sva (.SYS_CLK, .RESET_N, .SFR_ADDR, .SFR_WR, .SFR_WDATA,
   .SFR_RD, .SFR_RDATA, .SFR_SEL, .CHAN0, .CHAN1, .CHAN0_OE, .CHAN1_OE);

//--- verification/ddc_top_tb.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module ddc_top_tb;
   import ddc_pkg::*;
   logic SYS_CLK = 0, RESET_N = 0, SFR_WR = 0, SFR_RD = 0, SFR_SEL, CHAN0_OE, CHAN1_OE;
   logic [7:0] SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, SFR_RDATA;
   ddc_chan_t CHAN0, CHAN1;
   int error_cnt = 0, samples_checked = 0;
   // addr, data, code 0, code 1, {range, enable} shared by both channels
   logic [41:0] rows [14] = '{{8'hFD, 8'h1F, 24'h000000, 2'b01}, {8'hFA, 8'h03, 24'h000000, 2'b01},
      {8'hF9, 8'h45, 24'h345000, 2'b01}, {8'hFC, 8'h1A, 24'h345000, 2'b01},
      {8'hFB, 8'hBC, 24'h345ABC, 2'b01}, {8'hFD, 8'h1B, 24'h345ABC, 2'b01},
      {8'hF9, 8'h00, 24'h345ABC, 2'b01}, {8'hFB, 8'h11, 24'h345ABC, 2'b01},
      {8'hFD, 8'h1F, 24'h300A11, 2'b01}, {8'hFD, 8'hFB, 24'h300A11, 2'b11},
      {8'hFD, 8'hFF, 24'h000110, 2'b11}, {8'hF9, 8'h5A, 24'h5A0110, 2'b11},
      {8'hFD, 8'hE7, 24'h000000, 2'b11}, {8'hFD, 8'h04, 24'h000000, 2'b00}};
   ddc_top u_ddc_top (.SYS_CLK, .RESET_N, .SFR_ADDR, .SFR_WR, .SFR_WDATA, .SFR_RD, .SFR_RDATA,
      .SFR_SEL, .CHAN0, .CHAN1, .CHAN0_OE, .CHAN1_OE);
   always #4 SYS_CLK = ~SYS_CLK;
   task automatic chk(logic [14:0] got, logic [14:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // strobes drop one step after the edge, so each access leaves a gap cycle
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge SYS_CLK) #1 {SFR_ADDR, SFR_WDATA, SFR_WR} = {a, d, 1'b1};
      @(posedge SYS_CLK) #1 SFR_WR = 0;
   endtask
   task automatic rd(logic [7:0] a);
      @(posedge SYS_CLK) #1 {SFR_ADDR, SFR_RD} = {a, 1'b1};
      @(posedge SYS_CLK) #1 SFR_RD = 0;
   endtask
   task automatic end_sim;
      $display("checks=%0d errors=%0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #20000;
      error_cnt++;
      end_sim();
   end
   initial begin
      repeat (16) @(posedge SYS_CLK);
      #1 RESET_N = 1;
      foreach (rows[i]) begin
         wr(rows[i][41:34], rows[i][33:26]);
         chk({CHAN0_OE, CHAN0}, {rows[i][0], rows[i][25:14], rows[i][1:0]});
         chk({CHAN1_OE, CHAN1}, {rows[i][0], rows[i][13:2], rows[i][1:0]});
      end
      $display("table test done");
      // upper nibble of the high byte is kept for readback
      rd(8'hFC);
      chk({7'h00, SFR_RDATA}, 15'h001A);
      wr(8'hFD, 8'h1F);
      @(posedge SYS_CLK) #1 RESET_N = 0;
      @(posedge SYS_CLK) #1 chk({CHAN0_OE, CHAN0}, 15'h0000);
      chk({CHAN1_OE, CHAN1}, 15'h0000);
      RESET_N = 1;
      // unmapped F8 and FE must read back as zero and not select
      for (int a = 8'hF8; a <= 8'hFE; a++) begin
         rd(a[7:0]);
         chk({7'h00, SFR_RDATA}, (a == 8'hFD) ? 15'h0004 : 15'h0000);
         chk({14'h0000, SFR_SEL}, (a >= 8'hF9 && a <= 8'hFD) ? 15'h0001 : 15'h0000);
      end
      $display("reset test done");
      end_sim();
   end
endmodule
